// >>> inc/mccs_pkg.sv
package mccs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int REF_MHZ = 25;
  localparam int REF_DIV = CLK_MHZ / REF_MHZ;
  localparam int SQE_DELAY_NS = 800;
  localparam int SQE_LEN_NS = 1000;
  // Least delay rounds up, pulse length rounds down, both in reference ticks
  localparam int SQE_DELAY_TICKS = (SQE_DELAY_NS * REF_MHZ + 999) / 1000;
  localparam int SQE_LEN_TICKS = (SQE_LEN_NS * REF_MHZ) / 1000;
  localparam int SYM_BITS = 10;
  // ==========================================================
  // Management frame
  localparam int MDIO_PRE = 32;
  localparam int MDIO_FRAME = 64;
  localparam int MDIO_TA_IDX = 14;
  localparam int MDIO_DATA_IDX = 16;
  localparam int MDIO_LAST_IDX = 31;
  localparam logic [1:0] MDIO_ST = 2'h1;
  localparam logic [1:0] MDIO_OP_WR = 2'h1;
  localparam logic [1:0] MDIO_OP_RD = 2'h2;
  localparam logic [1:0] MDIO_TA_WR = 2'h2;
  localparam logic [1:0] MDIO_TA_RD = 2'h3;
  localparam logic [4:0] HB_REG = 5'h12;
  localparam int HB_BIT = 2;
  // ==========================================================
  // Controller registers
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_MDIO_CMD = 8'h14;
  localparam logic [7:0] REG_MDIO_RDATA = 8'h18;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_REP = 1;
  localparam int EV_COL = 0;
  localparam int EV_CRS = 1;
  localparam int EV_MDIO = 2;
  localparam int NUM_EV = 3;
  localparam int CMD_WR = 26;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {MG_IDLE, MG_BODY} mccs_mgmt_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_PULSE} mccs_sqe_t;
endpackage

// >>> inc/mccs_mii_if.sv
`timescale 1ns/1ps
interface mccs_mii_if;
  logic txen;
  logic col;
  logic crs;
  logic mdc;
  logic ref_tick;
  logic reset_n;
  logic node_repeater_select;
  logic sta_mdo;
  logic sta_mdo_en;
  logic phy_mdo;
  logic phy_mdo_en;
  logic mdio;
  // Shared line with pull-up when nobody drives it
  assign mdio = sta_mdo_en ? sta_mdo : (phy_mdo_en ? phy_mdo : 1'b1);
  modport phy (
    input txen, mdc, ref_tick, reset_n, node_repeater_select, mdio,
    output col, crs, phy_mdo, phy_mdo_en
  );
  modport mac (
    output txen, mdc, ref_tick, reset_n, node_repeater_select, sta_mdo, sta_mdo_en,
    input col, crs, mdio
  );
endinterface

// >>> hw/mccs_phy.sv
// Overview of operation
// - Collision when receiving while TXEN is high
// - 10M collision uses unsquelched receive activity
// - 100M activity: symbol has two non-adjacent zeros
// - COL unsynchronised; MAC must synchronise it
// - Full duplex holds COL low
// - Heartbeat COL after transmit in 10M half duplex node operation unless suppressed
// - Half duplex node: CRS on receive or transmit
// - Full duplex or repeater: CRS receive only
// - CRS unsynchronised; MAC must synchronise it
// - Management provides MDC; all transfers use it
// - Reset low holds device; high runs
// - System supplies the 25 MHz reference
// - Select high repeater, low node operation
// - MDIO shared three-state, timed by MDC
`timescale 1ns/1ps
module mccs_phy #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link toward the MAC
  mccs_mii_if.phy mii,
  // Line side activity
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic rx_unsq_active,
  input wire logic rx_sq_active,
  input wire logic rx_code_bit,
  input wire logic rx_code_en,
  // Status
  output logic heartbeat_test_suppress
);
  import mccs_pkg::*;

  // ==========================================================
  // Reset and mode
  logic run;
  logic rep;
  assign run = aresetn & mii.reset_n;
  assign rep = mii.node_repeater_select;

  // ==========================================================
  // Receive activity
  function automatic logic two_apart(input logic [SYM_BITS-1:0] s);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < SYM_BITS; i++)
    begin
      for (int j = i + 2; j < SYM_BITS; j++)
      begin
        if (!s[i] && !s[j])
          hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic [SYM_BITS-1:0] sym_r;
  logic sym_act;
  logic rx_col_act;
  logic rx_crs_act;
  // Every bit position starts a candidate symbol, so the window slides
  assign sym_act = two_apart(sym_r);
  assign rx_col_act = speed_100 ? sym_act : rx_unsq_active;
  assign rx_crs_act = speed_100 ? sym_act : rx_sq_active;

  always_ff @(posedge aclk)
  begin
    if (!run)
      sym_r <= '1;
    else if (rx_code_en)
      sym_r <= {sym_r[SYM_BITS-2:0], rx_code_bit};
  end

  // ==========================================================
  // Heartbeat after transmit, timed on the reference tick
  mccs_sqe_t sqe_r;
  logic [5:0] sqe_cnt_r;
  logic txen_d_r;
  logic hb_r;
  logic sqe_en;
  logic tx_fall;
  logic sqe_on;
  // Heartbeat belongs to half duplex 10M node operation only
  assign sqe_en = !hb_r && !full_duplex && !rep && !speed_100;
  assign tx_fall = txen_d_r && !mii.txen;
  assign sqe_on = (sqe_r == SQ_PULSE);

  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      sqe_r <= SQ_IDLE;
      sqe_cnt_r <= 6'h00;
      txen_d_r <= 1'b0;
    end
    else
    begin
      txen_d_r <= mii.txen;
      unique case (sqe_r)
        SQ_IDLE:
          if (tx_fall && sqe_en)
          begin
            sqe_r <= SQ_WAIT;
            sqe_cnt_r <= 6'(SQE_DELAY_TICKS);
          end
        SQ_WAIT:
          // A new transmit cancels the pending heartbeat
          if (mii.txen)
            sqe_r <= SQ_IDLE;
          else if (mii.ref_tick)
          begin
            if (sqe_cnt_r == 6'h01)
            begin
              sqe_r <= SQ_PULSE;
              sqe_cnt_r <= 6'(SQE_LEN_TICKS);
            end
            else
              sqe_cnt_r <= sqe_cnt_r - 6'h01;
          end
        SQ_PULSE:
          if (mii.ref_tick)
          begin
            if (sqe_cnt_r == 6'h01)
              sqe_r <= SQ_IDLE;
            else
              sqe_cnt_r <= sqe_cnt_r - 6'h01;
          end
      endcase
    end
  end

  // ==========================================================
  // Carrier and collision outputs
  logic col_nxt;
  logic crs_nxt;
  // Each follows its cause with one cycle of latency, no hold time
  assign col_nxt = !full_duplex && ((mii.txen && rx_col_act) || sqe_on);
  assign crs_nxt = (full_duplex || rep) ? rx_crs_act : (rx_crs_act || mii.txen);

  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      mii.col <= 1'b0;
      mii.crs <= 1'b0;
    end
    else
    begin
      mii.col <= col_nxt;
      mii.crs <= crs_nxt;
    end
  end
  // Outputs change only on aclk, never on the MII clocks

  // ==========================================================
  // Management slave
  mccs_mgmt_t mg_r;
  logic mdc_d_r;
  logic [5:0] ones_r;
  logic [4:0] k_r;
  logic [13:0] hdr_r;
  logic [15:0] wd_r;
  logic [15:0] rd_sh_r;
  logic mdc_rise;
  logic mdc_fall;
  logic hit;
  logic is_rd;
  logic is_wr;
  logic [15:0] rd_val;
  // Edges of the station clock steer every bit
  assign mdc_rise = mii.mdc && !mdc_d_r;
  assign mdc_fall = !mii.mdc && mdc_d_r;
  assign hit = (hdr_r[9:5] == PHY_ADDR);
  assign is_rd = hit && (hdr_r[11:10] == MDIO_OP_RD);
  assign is_wr = hit && (hdr_r[11:10] == MDIO_OP_WR);
  assign rd_val = (hdr_r[4:0] == HB_REG) ? 16'(hb_r) << HB_BIT : 16'h0000;

  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      mg_r <= MG_IDLE;
      mdc_d_r <= 1'b0;
      ones_r <= 6'h00;
      k_r <= 5'h00;
      hdr_r <= 14'h0000;
      wd_r <= 16'h0000;
      hb_r <= 1'b0;
    end
    else
    begin
      mdc_d_r <= mii.mdc;
      if (mdc_rise)
      begin
        unique case (mg_r)
          MG_IDLE:
            if (mii.mdio)
            begin
              if (ones_r != 6'(MDIO_PRE))
                ones_r <= ones_r + 6'h01;
            end
            else
            begin
              ones_r <= 6'h00;
              if (ones_r == 6'(MDIO_PRE))
              begin
                mg_r <= MG_BODY;
                k_r <= 5'h01;
                hdr_r <= 14'h0000;
              end
            end
          MG_BODY:
          begin
            k_r <= k_r + 5'h01;
            if (k_r < 5'(MDIO_TA_IDX))
              hdr_r <= {hdr_r[12:0], mii.mdio};
            if (k_r >= 5'(MDIO_DATA_IDX))
              wd_r <= {wd_r[14:0], mii.mdio};
            if (k_r == 5'(MDIO_LAST_IDX))
            begin
              mg_r <= MG_IDLE;
              if (is_wr && hdr_r[4:0] == HB_REG)
                hb_r <= wd_r[HB_BIT - 1];
            end
          end
        endcase
      end
    end
  end

  // Device drives only its turnaround zero and read data
  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      mii.phy_mdo <= 1'b1;
      mii.phy_mdo_en <= 1'b0;
      rd_sh_r <= 16'h0000;
    end
    else if (mdc_fall)
    begin
      if (mg_r == MG_BODY && is_rd && k_r >= 5'(MDIO_TA_IDX + 1))
      begin
        mii.phy_mdo_en <= 1'b1;
        if (k_r == 5'(MDIO_TA_IDX + 1))
          mii.phy_mdo <= 1'b0;
        else
        begin
          mii.phy_mdo <= rd_sh_r[15];
          rd_sh_r <= {rd_sh_r[14:0], 1'b0};
        end
      end
      else
      begin
        mii.phy_mdo_en <= 1'b0;
        mii.phy_mdo <= 1'b1;
        if (k_r == 5'(MDIO_TA_IDX))
          rd_sh_r <= rd_val;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      heartbeat_test_suppress <= 1'b0;
    else
      heartbeat_test_suppress <= hb_r;
  end
endmodule

// >>> hw/mccs_mac.sv
`timescale 1ns/1ps
module mccs_mac #(
  parameter int MDC_HALF = 40
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [mccs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [mccs_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // MAC core side
  input wire logic tx_en,
  output logic col_sync,
  output logic crs_sync,
  output logic irq,
  // Link toward the device
  mccs_mii_if.mac mii
);
  import mccs_pkg::*;

  // ==========================================================
  // Reference tick and line synchronisers
  logic [3:0] ref_cnt_r;
  logic col_s1_r;
  logic crs_s1_r;
  logic col_d_r;
  logic crs_d_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_cnt_r <= 4'h0;
      mii.ref_tick <= 1'b0;
      {col_s1_r, col_sync, col_d_r} <= 3'h0;
      {crs_s1_r, crs_sync, crs_d_r} <= 3'h0;
      mii.txen <= 1'b0;
    end
    else
    begin
      ref_cnt_r <= (ref_cnt_r == 4'(REF_DIV - 1)) ? 4'h0 : ref_cnt_r + 4'h1;
      mii.ref_tick <= (ref_cnt_r == 4'h0);
      col_s1_r <= mii.col;
      col_sync <= col_s1_r;
      col_d_r <= col_sync;
      crs_s1_r <= mii.crs;
      crs_sync <= crs_s1_r;
      crs_d_r <= crs_sync;
      mii.txen <= tx_en;
    end
  end

  // ==========================================================
  // Register decode
  logic [31:0] ctrl_r;
  logic [NUM_EV-1:0] stat_r;
  logic [NUM_EV-1:0] en_r;
  logic [15:0] mrd_r;
  logic busy_r;
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [31:0] wmask_r;
  logic do_wr;
  logic [31:0] wval;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] clr;
  logic [NUM_EV-1:0] stat_nxt;
  logic done_ev;
  logic rd_map;
  logic [31:0] rd_val;
  assign do_wr = aw_got_r && w_got_r && !bvalid;
  assign wval = (ctrl_r & ~wmask_r) | (w_data_r & wmask_r);
  assign clr = (do_wr && aw_addr_r == REG_IRQ_CLR) ? w_data_r[NUM_EV-1:0] : '0;
  assign ev = {done_ev, crs_sync && !crs_d_r, col_sync && !col_d_r};
  // A set in the clearing cycle wins
  assign stat_nxt = (stat_r & ~clr) | ev;
  assign rd_map = araddr == REG_CTRL || araddr == REG_STATUS || araddr == REG_IRQ_STAT
    || araddr == REG_IRQ_EN || araddr == REG_MDIO_CMD || araddr == REG_MDIO_RDATA;
  assign rd_val = (araddr == REG_CTRL) ? ctrl_r :
    (araddr == REG_STATUS) ? {29'h0, busy_r, crs_sync, col_sync} :
    (araddr == REG_IRQ_STAT) ? 32'(stat_r) :
    (araddr == REG_IRQ_EN) ? 32'(en_r) :
    (araddr == REG_MDIO_RDATA) ? {16'h0000, mrd_r} : 32'h00000000;
  assign mii.reset_n = ctrl_r[CTRL_RUN];
  assign mii.node_repeater_select = ctrl_r[CTRL_REP];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {awready, wready, bvalid, arready, rvalid} <= 5'h00;
      {aw_got_r, w_got_r} <= 2'h0;
      aw_addr_r <= '0;
      w_data_r <= 32'h00000000;
      wmask_r <= 32'h00000000;
      bresp <= RESP_OKAY;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
      ctrl_r <= 32'h00000000;
      en_r <= '0;
      stat_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      awready <= !aw_got_r && !(awvalid && awready);
      wready <= !w_got_r && !(wvalid && wready);
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= wdata;
        wmask_r <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      if (do_wr)
      begin
        {aw_got_r, w_got_r} <= 2'h0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_r == REG_CTRL || aw_addr_r == REG_IRQ_EN
          || aw_addr_r == REG_IRQ_CLR || aw_addr_r == REG_MDIO_CMD) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_r == REG_CTRL)
          ctrl_r <= wval & 32'h00000003;
        if (aw_addr_r == REG_IRQ_EN)
          en_r <= w_data_r[NUM_EV-1:0];
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
      stat_r <= stat_nxt;
      irq <= |(stat_nxt & en_r);
    end
  end

  // ==========================================================
  // Management frame master
  logic [MDIO_FRAME-1:0] frame_r;
  logic [5:0] idx_r;
  logic [7:0] half_r;
  logic is_rd_r;
  logic start;
  assign start = do_wr && aw_addr_r == REG_MDIO_CMD && !busy_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_r <= 1'b0;
      frame_r <= '0;
      idx_r <= 6'h00;
      half_r <= 8'h00;
      is_rd_r <= 1'b0;
      mrd_r <= 16'h0000;
      done_ev <= 1'b0;
      mii.mdc <= 1'b0;
      mii.sta_mdo <= 1'b1;
      mii.sta_mdo_en <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      if (start)
      begin
        busy_r <= 1'b1;
        is_rd_r <= !w_data_r[CMD_WR];
        frame_r <= {{MDIO_PRE{1'b1}}, MDIO_ST, w_data_r[CMD_WR] ? MDIO_OP_WR : MDIO_OP_RD,
          w_data_r[25:16], w_data_r[CMD_WR] ? MDIO_TA_WR : MDIO_TA_RD, w_data_r[15:0]};
        idx_r <= 6'h00;
        half_r <= 8'h00;
        mii.sta_mdo <= 1'b1;
        mii.sta_mdo_en <= 1'b1;
      end
      else if (busy_r)
      begin
        if (half_r == 8'(MDC_HALF - 1))
        begin
          half_r <= 8'h00;
          mii.mdc <= !mii.mdc;
          if (!mii.mdc)
          begin
            if (is_rd_r && idx_r >= 6'(MDIO_PRE + MDIO_DATA_IDX))
              mrd_r <= {mrd_r[14:0], mii.mdio};
          end
          else if (idx_r == 6'(MDIO_FRAME - 1))
          begin
            busy_r <= 1'b0;
            done_ev <= 1'b1;
            mii.sta_mdo_en <= 1'b0;
            mii.sta_mdo <= 1'b1;
          end
          else
          begin
            idx_r <= idx_r + 6'h01;
            frame_r <= {frame_r[MDIO_FRAME-2:0], 1'b0};
            mii.sta_mdo <= frame_r[MDIO_FRAME-2];
            // Let go of the line from turnaround on a read
            mii.sta_mdo_en <= !(is_rd_r && idx_r + 6'h01 >= 6'(MDIO_PRE + MDIO_TA_IDX));
          end
        end
        else
          half_r <= half_r + 8'h01;
      end
    end
  end
endmodule

// >>> sim/mccs_chk.sv
`timescale 1ns/1ps
// =====
// Link checker
module mccs_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic txen,
  input wire logic col,
  input wire logic crs,
  input wire logic mdc,
  input wire logic reset_n,
  input wire logic node_repeater_select,
  input wire logic sta_mdo_en,
  input wire logic phy_mdo_en,
  // Line side
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic rx_unsq_active,
  input wire logic rx_sq_active,
  input wire logic heartbeat_test_suppress
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire half10 = reset_n & !speed_100 & !full_duplex;
  // Heartbeat arms on a transmit end in node half duplex with the test allowed
  sequence s_hb_arm;
    $fell(txen) && half10 && !node_repeater_select && !heartbeat_test_suppress;
  endsequence
  sequence s_quiet;
    (!txen && !rx_unsq_active) [*8];
  endsequence
  AST_HB: assert property (s_hb_arm ##1 s_quiet |-> ##[130:190] col)
    else $error("heartbeat collision missing");
  AST_COL_FD: assert property (full_duplex && $past(full_duplex) |-> !col)
    else $error("collision in full duplex");
  AST_COL_RX: assert property (half10 && txen && rx_unsq_active |=> col)
    else $error("collision not reported");
  AST_COL_DROP: assert property (node_repeater_select && !txen |=> !col)
    else $error("collision held without transmit");
  AST_CRS_NODE: assert property (reset_n && !full_duplex && !node_repeater_select && txen
    |=> crs)
    else $error("carrier missing on transmit");
  AST_CRS_REP: assert property (reset_n && node_repeater_select && !speed_100
    && !rx_sq_active |=> !crs)
    else $error("carrier on own transmit");
  AST_RESET: assert property (!reset_n |=> !col && !crs && !phy_mdo_en)
    else $error("device active in reset");
  AST_MDIO_ONE: assert property (!(sta_mdo_en && phy_mdo_en))
    else $error("both ends drive the management line");
  AST_MDO_MDC: assert property ($rose(phy_mdo_en) |-> $past(mdc, 2) && !$past(mdc))
    else $error("device drive not after clock fall");
endmodule

// >>> sim/mii_carrier_collision_status_tb_top.sv
`timescale 1ns/1ps
module mii_carrier_collision_status_tb_top;
  import mccs_pkg::*;
  // Short management clock keeps each frame near 256 cycles
  localparam int MDC_H = 2;
  localparam logic [4:0] PA = 5'h01;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic tx_en = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0;
  logic rx_unsq_active = 1'b0, rx_sq_active = 1'b0, rx_code_bit = 1'b1, rx_code_en = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, col_sync, crs_sync, irq;
  logic heartbeat_test_suppress;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int errors = 0;
  int compares = 0;
  int hb;
  always #2.5 aclk = ~aclk;
  mccs_mii_if mii_bus ();
  mccs_phy #(.PHY_ADDR(PA)) i_mccs_phy (.aclk(aclk), .aresetn(aresetn), .mii(mii_bus),
    .speed_100(speed_100), .full_duplex(full_duplex), .rx_unsq_active(rx_unsq_active),
    .rx_sq_active(rx_sq_active), .rx_code_bit(rx_code_bit), .rx_code_en(rx_code_en),
    .heartbeat_test_suppress(heartbeat_test_suppress));
  mccs_mac #(.MDC_HALF(MDC_H)) i_mccs_mac (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tx_en(tx_en), .col_sync(col_sync),
    .crs_sync(crs_sync), .irq(irq), .mii(mii_bus));
  mccs_chk i_mccs_chk (.aclk(aclk), .aresetn(aresetn), .txen(mii_bus.txen),
    .col(mii_bus.col), .crs(mii_bus.crs), .mdc(mii_bus.mdc), .reset_n(mii_bus.reset_n),
    .node_repeater_select(mii_bus.node_repeater_select), .sta_mdo_en(mii_bus.sta_mdo_en),
    .phy_mdo_en(mii_bus.phy_mdo_en), .speed_100(speed_100), .full_duplex(full_duplex),
    .rx_unsq_active(rx_unsq_active), .rx_sq_active(rx_sq_active),
    .heartbeat_test_suppress(heartbeat_test_suppress));
  // =====
  // Tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Waits as long as the slave needs; only the watchdog ends a hung transfer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic send_sym(input logic [9:0] s);
    for (int i = 9; i >= 0; i--)
    begin
      @(posedge aclk);
      rx_code_bit <= s[i];
      rx_code_en <= 1'b1;
    end
    @(posedge aclk);
    rx_code_en <= 1'b0;
  endtask
  // One short transmit, then count collision cycles while the line is silent
  task automatic hb_count();
    hb = 0;
    @(posedge aclk);
    tx_en <= 1'b1;
    repeat (20) @(posedge aclk);
    tx_en <= 1'b0;
    repeat (500)
    begin
      @(posedge aclk);
      if (mii_bus.col)
        hb++;
    end
  endtask
  // Frame length is fixed by the management clock divider
  task automatic mdio(input logic [31:0] cmd);
    axi_wr(REG_MDIO_CMD, cmd);
    chk_val(rs, RESP_OKAY);
    axi_rd(REG_STATUS);
    chk_val(rd[2], 1'b1);
    repeat (128 * MDC_H + 8) @(posedge aclk);
    axi_rd(REG_STATUS);
    chk_val(rd[2], 1'b0);
  endtask
  // =====
  // Tests
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    tx_en <= 1'b1;
    rx_unsq_active <= 1'b1;
    axi_rd(REG_CTRL);
    chk_val(rd, 32'h0);
    chk_val(rs, RESP_OKAY);
    axi_rd(8'h1C);
    chk_val(rs, RESP_SLVERR);
    chk_val(rd, 32'h0);
    axi_rd(REG_IRQ_CLR);
    chk_val(rs, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h1);
    chk_val(rs, RESP_SLVERR);
    chk_val(mii_bus.col, 1'b0);
    axi_wr(REG_IRQ_EN, 32'h1 << EV_COL);
    axi_wr(REG_CTRL, 32'h1);
    repeat (6) @(posedge aclk);
    chk_val(col_sync, 1'b1);
    chk_val(crs_sync, 1'b1);
    chk_val(irq, 1'b1);
    axi_rd(REG_STATUS);
    chk_val(rd, 32'h3);
    rx_unsq_active <= 1'b0;
    rx_sq_active <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_val(col_sync, 1'b0);
    axi_wr(REG_IRQ_CLR, 32'h1 << EV_COL);
    repeat (2) @(posedge aclk);
    chk_val(irq, 1'b0);
    axi_wr(REG_IRQ_EN, 32'h0);
    rx_unsq_active <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_val(irq, 1'b0);
    axi_rd(REG_IRQ_STAT);
    chk_val(rd[EV_COL], 1'b1);
    chk_val(rd, 32'h3);
    tx_en <= 1'b0;
    rx_unsq_active <= 1'b0;
    rx_sq_active <= 1'b0;
    repeat (400) @(posedge aclk);
    full_duplex <= 1'b1;
    tx_en <= 1'b1;
    rx_unsq_active <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_val(col_sync, 1'b0);
    chk_val(crs_sync, 1'b0);
    rx_sq_active <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_val(crs_sync, 1'b1);
    tx_en <= 1'b0;
    rx_unsq_active <= 1'b0;
    rx_sq_active <= 1'b0;
    repeat (4) @(posedge aclk);
    full_duplex <= 1'b0;
    axi_wr(REG_CTRL, 32'h3);
    tx_en <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_val(crs_sync, 1'b0);
    rx_sq_active <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_val(crs_sync, 1'b1);
    tx_en <= 1'b0;
    rx_sq_active <= 1'b0;
    hb_count();
    chk_val(hb != 0, 1'b0);
    axi_wr(REG_CTRL, 32'h1);
    hb_count();
    chk_val(hb != 0, 1'b1);
    mdio({5'h0, 1'b1, PA, HB_REG, 16'h0004});
    chk_val(heartbeat_test_suppress, 1'b1);
    axi_rd(REG_IRQ_STAT);
    chk_val(rd[EV_MDIO], 1'b1);
    hb_count();
    chk_val(hb != 0, 1'b0);
    mdio({6'h0, PA, HB_REG, 16'h0});
    axi_rd(REG_MDIO_RDATA);
    chk_val(rd[15:0], 16'h0004);
    mdio({6'h0, PA + 5'h1, HB_REG, 16'h0});
    axi_rd(REG_MDIO_RDATA);
    chk_val(rd[15:0], 16'hFFFF);
    speed_100 <= 1'b1;
    tx_en <= 1'b1;
    send_sym(10'b0011111111);
    repeat (6) @(posedge aclk);
    chk_val(col_sync, 1'b0);
    send_sym(10'b0101111111);
    repeat (6) @(posedge aclk);
    chk_val(col_sync, 1'b1);
    send_sym(10'h3FF);
    repeat (6) @(posedge aclk);
    chk_val(col_sync, 1'b0);
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    test_done();
  end
endmodule
